/* design/fpoct_core.sv */
`timescale 1ns/1ps
`include "fpoct_defines.svh"
module fpoct_core #(
  parameter int UC_W  = `FPOCT_UC_W,
  parameter int REG_W = 64,
  parameter int NREG  = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  start_i,
  input  wire fpoct_pkg::fpoct_op_e  op_i,
  input  wire logic                  dbl_i,
  input  wire logic                  long_i,
  input  wire logic [UC_W-1:0]       base_uc_i,
  input  wire logic                  res_pos_i,
  input  wire logic                  res_nz_i,
  input  wire logic                  nz_applies_i,
  input  wire logic                  operand_zero_i,
  input  wire logic signed [15:0]    operand_value_i,
  input  wire logic                  cmp_eq_i,
  input  wire logic                  cmp_same_sign_i,
  input  wire logic [7:0]            exp_diff_i,
  input  wire logic [7:0]            norm_shifts_i,
  input  wire logic [63:0]           source_operand_i,
  input  wire logic                  md_norm_i,
  input  wire logic                  round_i,
  input  wire logic                  trap_ovf_i,
  input  wire logic                  trap_unf_i,
  input  wire logic                  trap_any_i,
  input  wire logic                  trap_conv_i,
  input  wire logic                  irq_req_i,
  input  wire logic [NREG*REG_W-1:0] regs_i,
  output logic                       busy_o,
  output logic                       done_o,
  output logic                       irq_ack_o,
  output logic                       restore_o,
  output logic                       restart_pend_o,
  output logic [NREG*REG_W-1:0]      regs_restore_o,
  output logic [UC_W-1:0]            total_uc_o
);
  typedef struct packed {
    fpoct_pkg::fpoct_state_e st;
    fpoct_pkg::fpoct_op_e    op;
    logic                    done;
    logic                    ack;
    logic                    rest;
    logic                    pend;
    logic                    busy;
    logic [UC_W-1:0]         total;
    logic [NREG*REG_W-1:0]   shadow;
  } fpoct_core_s;
  fpoct_core_s s_r;
  fpoct_core_s s_nxt;

  logic            t_load;
  logic [UC_W-1:0] t_count;
  logic            t_abort;
  logic            t_done;
  logic            t_busy;

  // converts a printed ns figure to whole microcycles, rounding up
  function automatic logic [UC_W-1:0] uc(input int ns);
    uc = UC_W'((ns + `FPOCT_UCYC_NS - 1) / `FPOCT_UCYC_NS);
  endfunction : uc

  // ones in the multiplier: the single form looks only at its upper 32 bits
  function automatic logic [UC_W-1:0] ones(input logic [63:0] v, input logic dbl);
    logic [UC_W-1:0] n;
    n = '0;
    for (int i = 0; i < 64; i++) begin
      if (v[i] && (dbl || i >= 32)) begin
        n = n + UC_W'(1);
      end
    end
    ones = n;
  endfunction : ones

  function automatic logic is_arith(input fpoct_pkg::fpoct_op_e op);
    is_arith = (op == fpoct_pkg::OP_ADD) || (op == fpoct_pkg::OP_SUB) ||
               (op == fpoct_pkg::OP_MUL) || (op == fpoct_pkg::OP_DIV) ||
               (op == fpoct_pkg::OP_MOD);
  endfunction : is_arith

  // op classes used by the increments below; only the add/subtract class feeds more than one
  logic op_addsub;
  logic op_muldiv;
  logic op_unary;
  logic exp_out;
  always_comb begin
    op_addsub = (op_i == fpoct_pkg::OP_ADD) || (op_i == fpoct_pkg::OP_SUB);
    op_muldiv = (op_i == fpoct_pkg::OP_MUL) || (op_i == fpoct_pkg::OP_DIV);
    op_unary  = (op_i == fpoct_pkg::OP_TST) || (op_i == fpoct_pkg::OP_ABS) ||
                (op_i == fpoct_pkg::OP_NEG) || (op_i == fpoct_pkg::OP_LDEXP);
    // signed compare, so a large negative exponent word is not read as huge
    exp_out   = (operand_value_i > $signed(`FPOCT_EXP_LIM)) ||
                (operand_value_i < -$signed(`FPOCT_EXP_LIM));
  end

  // one term per data condition; a term is zero when its op or data rule it out
  logic [UC_W-1:0] inc_pos;
  logic [UC_W-1:0] inc_nz;
  logic [UC_W-1:0] inc_cvz;
  logic [UC_W-1:0] inc_exp;
  logic [UC_W-1:0] inc_cmp;
  logic [UC_W-1:0] inc_algn;
  logic [UC_W-1:0] inc_nrm;
  logic [UC_W-1:0] inc_mbit;
  logic [UC_W-1:0] inc_mdn;
  logic [UC_W-1:0] inc_rnd;
  logic [UC_W-1:0] inc_ovf;
  logic [UC_W-1:0] inc_unf;
  logic [UC_W-1:0] inc_utrp;
  logic [UC_W-1:0] inc_cvi;

  always_comb begin
    inc_pos  = '0;
    inc_nz   = '0;
    inc_cvz  = '0;
    inc_exp  = '0;
    inc_cmp  = '0;
    inc_algn = '0;
    inc_nrm  = '0;
    inc_mbit = '0;
    inc_mdn  = '0;
    inc_rnd  = '0;
    inc_ovf  = '0;
    inc_unf  = '0;
    inc_utrp = '0;
    inc_cvi  = '0;
    if (res_pos_i) begin
      inc_pos = uc(`FPOCT_T_POS_NS);
    end
    if (res_nz_i && nz_applies_i) begin
      inc_nz = uc(`FPOCT_T_NZ_NS);
    end
    if ((op_i == fpoct_pkg::OP_CONV) && operand_zero_i) begin
      inc_cvz = uc(`FPOCT_T_CVZ_NS);
    end
    if ((op_i == fpoct_pkg::OP_LDEXP) && exp_out) begin
      inc_exp = uc(`FPOCT_T_EXPR_NS);
    end
    // equal wins over same sign; differing signs add nothing
    if (op_i == fpoct_pkg::OP_CMP) begin
      if (cmp_eq_i) begin
        inc_cmp = uc(`FPOCT_T_CMPEQ_NS);
      end else if (cmp_same_sign_i) begin
        inc_cmp = uc(`FPOCT_T_CMPSS_NS);
      end
    end
    // double add and subtract carry no alignment charge
    if (op_addsub && !dbl_i) begin
      inc_algn = uc(`FPOCT_T_ALGN_NS) +
                 UC_W'(exp_diff_i) * uc(`FPOCT_T_ALGN1_NS);
    end
    if (op_addsub) begin
      inc_nrm = UC_W'(norm_shifts_i) *
                (dbl_i ? uc(`FPOCT_T_NRMD_NS) : uc(`FPOCT_T_NRMF_NS));
    end
    // the multiplier's one bits set the step count
    if (op_i == fpoct_pkg::OP_MUL) begin
      inc_mbit = ones(source_operand_i, dbl_i) *
                 (dbl_i ? uc(`FPOCT_T_MBD_NS) : uc(`FPOCT_T_MBF_NS));
    end
    if (op_muldiv && md_norm_i) begin
      inc_mdn = dbl_i ? uc(`FPOCT_T_MND_NS) : uc(`FPOCT_T_MNF_NS);
    end
    if (is_arith(op_i) && round_i) begin
      inc_rnd = dbl_i ? uc(`FPOCT_T_RNDD_NS) : uc(`FPOCT_T_RNDF_NS);
    end
    // both traps may be flagged at once; each charges its own time
    if (is_arith(op_i) && trap_ovf_i) begin
      inc_ovf = uc(`FPOCT_T_OVF_NS);
    end
    if (is_arith(op_i) && trap_unf_i) begin
      inc_unf = uc(`FPOCT_T_UNF_NS);
    end
    if (op_unary && trap_any_i) begin
      inc_utrp = uc(`FPOCT_T_UTRP_NS);
    end
    if ((op_i == fpoct_pkg::OP_STCI) && trap_conv_i) begin
      inc_cvi = long_i ? uc(`FPOCT_T_CVL_NS) : uc(`FPOCT_T_CVS_NS);
    end
  end

  // sum of base and every increment; wraps silently past the counter width
  logic [UC_W-1:0] sum_uc;
  always_comb begin
    sum_uc = base_uc_i;
    sum_uc = sum_uc + inc_pos + inc_nz + inc_cvz + inc_exp;
    sum_uc = sum_uc + inc_cmp + inc_algn + inc_nrm;
    sum_uc = sum_uc + inc_mbit + inc_mdn + inc_rnd;
    sum_uc = sum_uc + inc_ovf + inc_unf + inc_utrp + inc_cvi;
  end

  // interrupts count only from flops; irq_req_i is same-clock logic
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.ack  = 1'b0;
    t_load     = 1'b0;
    t_count    = '0;
    t_abort    = 1'b0;
    case (s_r.st)
      fpoct_pkg::ST_IDLE: begin
        if (irq_req_i) begin
          // one pulse per request: the host drops it only after seeing the pulse
          if (!s_r.ack) begin
            s_nxt.ack = 1'b1; // between operations interrupts are taken at once
          end
        end else if (start_i) begin
          s_nxt.st     = fpoct_pkg::ST_RUN;
          s_nxt.busy   = 1'b1;
          s_nxt.op     = op_i;
          s_nxt.total  = sum_uc;
          s_nxt.shadow = regs_i;
          s_nxt.pend   = 1'b0;
          t_load       = 1'b1;
          t_count      = sum_uc;
        end
      end
      fpoct_pkg::ST_RUN: begin
        if (irq_req_i && is_arith(s_r.op)) begin
          // abandon; no partial progress is kept
          t_abort    = 1'b1;
          s_nxt.st   = fpoct_pkg::ST_RESTORE;
          s_nxt.rest = 1'b1;
          t_load     = 1'b1;
          t_count    = uc(`FPOCT_T_RST_NS);
        end else if (t_done) begin
          // other ops and extended integer ops finish first
          s_nxt.st   = fpoct_pkg::ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.ack  = irq_req_i;
        end
      end
      fpoct_pkg::ST_RESTORE: begin
        if (t_done) begin
          s_nxt.st   = fpoct_pkg::ST_IDLE;
          s_nxt.rest = 1'b0;
          s_nxt.busy = 1'b0;
          s_nxt.ack  = 1'b1; // restore time lands in the latency
          s_nxt.pend = 1'b1; // host reissues the op from scratch
        end
      end
      default: begin
        s_nxt.st   = fpoct_pkg::ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // one register for all state; reset clears every flag and the shadow copy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // shared microcycle timer: run length first, then the restore time
  fpoct_ucyc_timer #(
    .UC_W (UC_W)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (t_load),
    .count_i (t_count),
    .abort_i (t_abort),
    .done_o  (t_done),
    .busy_o  (t_busy)
  );

  // all outputs straight from state flops
  assign busy_o         = s_r.busy;
  assign done_o         = s_r.done;
  assign irq_ack_o      = s_r.ack;
  assign restore_o      = s_r.rest;
  assign restart_pend_o = s_r.pend;
  assign regs_restore_o = s_r.shadow;
  assign total_uc_o     = s_r.total;
endmodule : fpoct_core

/* design/fpoct_defines.svh */
`ifndef FPOCT_DEFINES_SVH
`define FPOCT_DEFINES_SVH
// microcycle period and increments, printed figures in ns
`define FPOCT_CLK_NS        40
`define FPOCT_UCYC_NS       300
`define FPOCT_CYC(ns)       (((ns) + `FPOCT_CLK_NS - 1) / `FPOCT_CLK_NS)
`define FPOCT_T_POS_NS      300
`define FPOCT_T_NZ_NS       300
`define FPOCT_T_CVZ_NS      900
`define FPOCT_T_EXPR_NS     900
`define FPOCT_T_CMPEQ_NS    1200
`define FPOCT_T_CMPSS_NS    2100
`define FPOCT_T_ALGN_NS     900
`define FPOCT_T_ALGN1_NS    1200
`define FPOCT_T_NRMF_NS     1200
`define FPOCT_T_NRMD_NS     1800
`define FPOCT_T_MBF_NS      600
`define FPOCT_T_MBD_NS      1200
`define FPOCT_T_MNF_NS      600
`define FPOCT_T_MND_NS      1200
`define FPOCT_T_RNDF_NS     1200
`define FPOCT_T_RNDD_NS     1800
`define FPOCT_T_OVF_NS      8100
`define FPOCT_T_UNF_NS      9000
`define FPOCT_T_UTRP_NS     4500
`define FPOCT_T_CVS_NS      24300
`define FPOCT_T_CVL_NS      24900
`define FPOCT_T_RST_NS      6900
`define FPOCT_EXP_LIM       16'h007f
`define FPOCT_UC_W          16
`endif

/* design/fpoct_pkg.sv */
package fpoct_pkg;
  typedef enum logic [3:0] {
    OP_OTHER = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_MUL = 4'h3, OP_DIV = 4'h4,
    OP_MOD = 4'h5, OP_CMP = 4'h6, OP_CONV = 4'h7, OP_LDEXP = 4'h8, OP_TST = 4'h9,
    OP_ABS = 4'ha, OP_NEG = 4'hb, OP_STCI = 4'hc, OP_EXTI = 4'hd
  } fpoct_op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_RESTORE = 2'b10
  } fpoct_state_e;
endpackage : fpoct_pkg

/* design/fpoct_ucyc_timer.sv */
`timescale 1ns/1ps
`include "fpoct_defines.svh"
// divides the clock into microcycle ticks and counts whole microcycles down
module fpoct_ucyc_timer #(
  parameter int UC_W = `FPOCT_UC_W
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            load_i,
  input  wire logic [UC_W-1:0] count_i,
  input  wire logic            abort_i,
  output logic                 done_o,
  output logic                 busy_o
);
  localparam int DIV = `FPOCT_CYC(`FPOCT_UCYC_NS);
  typedef struct packed {
    logic [7:0]      div;
    logic [UC_W-1:0] cnt;
    logic            busy;
    logic            done;
  } fpoct_tmr_s;
  fpoct_tmr_s s_r;
  fpoct_tmr_s s_nxt;

  // a load restarts the divider so every count is whole microcycles
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (load_i) begin
      s_nxt.div  = 8'h00;
      s_nxt.cnt  = count_i;
      s_nxt.busy = (count_i != '0);
      s_nxt.done = (count_i == '0);
    end else if (abort_i) begin
      s_nxt.busy = 1'b0;
      s_nxt.cnt  = '0;
    end else if (s_r.busy) begin
      if (s_r.div == 8'(DIV - 1)) begin
        s_nxt.div = 8'h00;
        s_nxt.cnt = s_r.cnt - 1'b1;
        if (s_r.cnt == UC_W'(1)) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      end else begin
        s_nxt.div = s_r.div + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_o = s_r.done;
  assign busy_o = s_r.busy;
endmodule : fpoct_ucyc_timer

/* bench/fpoct_core_props.sv */
`timescale 1ns/1ps
// port-level timing checks; one microcycle is eight clocks here
module fpoct_core_props #(
  parameter int UC_W  = 16,
  parameter int REG_W = 64,
  parameter int NREG  = 8
) (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  start_i,
  input wire fpoct_pkg::fpoct_op_e  op_i,
  input wire logic                  irq_req_i,
  input wire logic [NREG*REG_W-1:0] regs_i,
  input wire logic                  busy_o,
  input wire logic                  done_o,
  input wire logic                  irq_ack_o,
  input wire logic                  restore_o,
  input wire logic                  restart_pend_o,
  input wire logic [NREG*REG_W-1:0] regs_restore_o,
  input wire logic [UC_W-1:0]       total_uc_o
);
  logic                  take;
  logic                  arith_r;
  int                    cnt_r;
  int                    rcnt_r;
  logic [NREG*REG_W-1:0] shadow_r;
  // a start counts in idle whenever no interrupt is requested
  assign take = start_i && !busy_o && !irq_req_i;
  // own copy of the state at take, so a stuck shadow in the core shows up
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r    <= 0;
      rcnt_r   <= 0;
      arith_r  <= 1'b0;
      shadow_r <= '0;
    end else begin
      cnt_r  <= take ? 0 : cnt_r + 1; // edges since the take
      rcnt_r <= restore_o ? rcnt_r + 1 : 0;
      if (take) begin
        arith_r  <= op_i inside {[fpoct_pkg::OP_ADD:fpoct_pkg::OP_MOD]};
        shadow_r <= regs_i;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_abort_end;
    irq_ack_o && restart_pend_o && !busy_o;
  endsequence
  sequence s_restore_begin;
    $rose(restore_o);
  endsequence
  AST_TAKE: assert property (take |=> busy_o && !restart_pend_o)
    else $error("start not taken");
  AST_DURATION: assert property (done_o |-> cnt_r == 8 * int'(total_uc_o) + 1)
    else $error("operation length wrong");
  AST_DONE_PULSE: assert property (done_o |=> !done_o && !busy_o)
    else $error("done not a pulse");
  AST_TOTAL_HOLD: assert property (busy_o && $past(busy_o) |-> $stable(total_uc_o))
    else $error("total moved while busy");
  AST_RESTORE_LEN: assert property ($fell(restore_o) |-> rcnt_r == 185)
    else $error("restore length wrong");
  AST_ABORT_END: assert property ($fell(restore_o) |-> s_abort_end)
    else $error("abort end wrong");
  AST_ONLY_ARITH: assert property (s_restore_begin |-> arith_r)
    else $error("restore on non-arith op");
  AST_SHADOW: assert property (s_restore_begin |-> regs_restore_o == shadow_r)
    else $error("shadow copy wrong");
  AST_ABORT: assert property (
    busy_o && !restore_o && arith_r && irq_req_i && cnt_r < 8 * int'(total_uc_o) - 1
    |=> restore_o) else $error("arith op not aborted");
  AST_HOLD: assert property (busy_o && !arith_r |-> !restore_o && !irq_ack_o)
    else $error("interrupt taken mid-op");
endmodule : fpoct_core_props

/* bench/fpoct_host_model.sv */
`timescale 1ns/1ps
// host core: request held until acknowledged; registers keep moving
module fpoct_host_model (
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  input  wire logic    raise_i,
  input  wire logic    irq_ack_i,
  output logic         irq_req_o,
  output logic [511:0] regs_o
);
  // moving registers catch a shadow captured late instead of at take
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_req_o <= 1'b0;
      regs_o    <= {8{64'h0123456789abcdef}};
    end else begin
      irq_req_o <= raise_i | (irq_req_o & ~irq_ack_i);
      regs_o    <= {regs_o[510:0], regs_o[511] ^ regs_o[500]};
    end
  end
endmodule : fpoct_host_model

/* bench/fpoct_core_test.sv */
`timescale 1ns/1ps
module fpoct_core_test;
  logic clk_i, rst_n_i, start_i, dbl_i, long_i, res_pos_i, res_nz_i, nz_applies_i, raise_i;
  logic operand_zero_i, cmp_eq_i, cmp_same_sign_i, md_norm_i, round_i, irq_req_i;
  logic trap_ovf_i, trap_unf_i, trap_any_i, trap_conv_i, busy_o, done_o, irq_ack_o;
  logic restore_o, restart_pend_o;
  fpoct_pkg::fpoct_op_e op_i;
  logic [15:0]          base_uc_i, total_uc_o;
  logic signed [15:0]   operand_value_i;
  logic [7:0]           exp_diff_i, norm_shifts_i;
  logic [63:0]          source_operand_i;
  logic [511:0]         regs_i, regs_restore_o, regs_t;
  logic [31:0]          sd;
  int                   n_mismatch, checks_done, n_exp, c, i;
  logic signed [15:0]   lim [4] = '{16'sh007f, 16'sh0080, -16'sh007f, -16'sh0080};
  fpoct_pkg::fpoct_op_e nai [2] = '{fpoct_pkg::OP_TST, fpoct_pkg::OP_EXTI};

  fpoct_core i_fpoct_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
    .dbl_i(dbl_i), .long_i(long_i), .base_uc_i(base_uc_i), .res_pos_i(res_pos_i),
    .res_nz_i(res_nz_i), .nz_applies_i(nz_applies_i), .operand_zero_i(operand_zero_i),
    .operand_value_i(operand_value_i), .cmp_eq_i(cmp_eq_i), .cmp_same_sign_i(cmp_same_sign_i),
    .exp_diff_i(exp_diff_i), .norm_shifts_i(norm_shifts_i), .md_norm_i(md_norm_i),
    .source_operand_i(source_operand_i), .round_i(round_i), .trap_ovf_i(trap_ovf_i),
    .trap_unf_i(trap_unf_i), .trap_any_i(trap_any_i), .trap_conv_i(trap_conv_i),
    .irq_req_i(irq_req_i), .regs_i(regs_i), .busy_o(busy_o), .done_o(done_o),
    .irq_ack_o(irq_ack_o), .restore_o(restore_o), .restart_pend_o(restart_pend_o),
    .regs_restore_o(regs_restore_o), .total_uc_o(total_uc_o));
  fpoct_host_model i_fpoct_host_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .raise_i(raise_i),
    .irq_ack_i(irq_ack_o), .irq_req_o(irq_req_i), .regs_o(regs_i));

  // clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected microcycles from the data conditions now on the inputs
  function automatic int exp_uc();
    int n;
    logic ar;
    logic ad;
    ar = op_i inside {[fpoct_pkg::OP_ADD:fpoct_pkg::OP_MOD]};
    ad = op_i inside {fpoct_pkg::OP_ADD, fpoct_pkg::OP_SUB};
    n = base_uc_i + res_pos_i + (res_nz_i & nz_applies_i);
    if (op_i == fpoct_pkg::OP_CONV && operand_zero_i) n += 3;
    if (op_i == fpoct_pkg::OP_LDEXP && (operand_value_i > 127 || operand_value_i < -127))
      n += 3;
    if (op_i == fpoct_pkg::OP_CMP) n += cmp_eq_i ? 4 : (cmp_same_sign_i ? 7 : 0);
    if (ad) n += (dbl_i ? 0 : 3 + 4 * exp_diff_i) + norm_shifts_i * (dbl_i ? 6 : 4);
    if (op_i == fpoct_pkg::OP_MUL)
      n += $countones(dbl_i ? source_operand_i : source_operand_i[63:32]) *
           (dbl_i ? 4 : 2);
    if (op_i inside {fpoct_pkg::OP_MUL, fpoct_pkg::OP_DIV} && md_norm_i)
      n += dbl_i ? 4 : 2;
    if (ar && round_i) n += dbl_i ? 6 : 4;
    if (ar) n += (trap_ovf_i ? 27 : 0) + (trap_unf_i ? 30 : 0);
    if (trap_any_i && op_i inside {[fpoct_pkg::OP_LDEXP:fpoct_pkg::OP_NEG]}) n += 15;
    if (op_i == fpoct_pkg::OP_STCI && trap_conv_i) n += long_i ? 83 : 81;
    return n;
  endfunction : exp_uc

  task automatic bad(input logic [511:0] got, input logic [511:0] exp);
    n_mismatch++;
    $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
  endtask : bad

  task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) bad(512'(got), 512'(exp));
  endtask : cmp_v

  task automatic cmp_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) bad(512'(got), 512'(exp));
  endtask : cmp_b

  task automatic cmp_r(input logic [511:0] got, input logic [511:0] exp);
    checks_done++;
    if (got !== exp) bad(got, exp);
  endtask : cmp_r

  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // random data conditions; base kept small so the run stays short
  task automatic rnd(input fpoct_pkg::fpoct_op_e op, input logic fix, input logic signed [15:0] v);
    repeat (32) sd = lfsr(sd);
    op_i <= op;
    {dbl_i, long_i, res_pos_i, res_nz_i, nz_applies_i, operand_zero_i, cmp_eq_i, cmp_same_sign_i,
     md_norm_i, round_i, trap_ovf_i, trap_unf_i, trap_any_i, trap_conv_i} <= sd[13:0];
    base_uc_i        <= {10'h0, sd[19:14]} + 16'h1;
    exp_diff_i       <= {4'h0, sd[23:20]};
    norm_shifts_i    <= {4'h0, sd[27:24]};
    operand_value_i  <= fix ? v : sd[31:16];
    source_operand_i <= {sd, ~sd};
  endtask : rnd

  // start held four cycles: the three repeats while busy must be ignored
  task automatic go(input int irq_at);
    start_i <= 1'b1;
    // registers move every edge: copy them in the half cycle before the take
    @(negedge clk_i);
    regs_t = regs_i;
    @(posedge clk_i);
    #1;
    n_exp = exp_uc();
    cmp_v(total_uc_o, 16'(n_exp));
    c = 0;
    while (!(done_o || irq_ack_o) && c < 5000) begin
      @(posedge clk_i);
      c++;
      start_i <= (c < 3);
      raise_i <= (c == irq_at);
      #1;
    end
    if (c >= 5000) begin
      n_mismatch++;
      test_done();
    end
    if (done_o) cmp_v(16'(c), 16'(8 * n_exp + 1));
  endtask : go

  initial begin
    {start_i, dbl_i, long_i, res_pos_i, res_nz_i, nz_applies_i, operand_zero_i, cmp_eq_i,
     cmp_same_sign_i, md_norm_i, round_i, raise_i, trap_ovf_i, trap_unf_i, trap_any_i,
     trap_conv_i, rst_n_i} = '0;
    op_i = fpoct_pkg::OP_OTHER;
    {base_uc_i, operand_value_i, exp_diff_i, norm_shifts_i, source_operand_i} = '0;
    sd = 32'h0000003f;
    n_mismatch = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // every op class twice, random data
    for (i = 0; i < 28; i++) begin
      @(posedge clk_i);
      rnd(fpoct_pkg::fpoct_op_e'(4'(i % 14)), 1'b0, 16'sh0);
      go(0);
    end
    // exponent just inside and just beyond the limit
    foreach (lim[k]) begin
      @(posedge clk_i);
      rnd(fpoct_pkg::OP_LDEXP, 1'b1, lim[k]);
      go(0);
    end
    // arithmetic op interrupted, then reissued with the same data
    @(posedge clk_i);
    rnd(fpoct_pkg::OP_ADD, 1'b0, 16'sh0);
    go(2);
    cmp_b(irq_ack_o, 1'b1);
    cmp_b(restart_pend_o, 1'b1);
    cmp_r(regs_restore_o, regs_t);
    repeat (3) @(posedge clk_i);
    go(0);
    cmp_b(restart_pend_o, 1'b0);
    // interrupt pending during non-arithmetic ops waits for completion
    foreach (nai[k]) begin
      @(posedge clk_i);
      rnd(nai[k], 1'b0, 16'sh0);
      go(2);
      cmp_b(done_o & irq_ack_o, 1'b1);
      repeat (3) @(posedge clk_i);
    end
    test_done();
  end
endmodule : fpoct_core_test

bind fpoct_core fpoct_core_props #(.UC_W(UC_W), .REG_W(REG_W), .NREG(NREG)) i_fpoct_core_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i), .irq_req_i(irq_req_i),
  .regs_i(regs_i), .busy_o(busy_o), .done_o(done_o), .irq_ack_o(irq_ack_o),
  .restore_o(restore_o), .restart_pend_o(restart_pend_o), .regs_restore_o(regs_restore_o),
  .total_uc_o(total_uc_o));
